// *** shz_pkg.sv ***
// package for the shift/logic unit issue hazard block
package shz_pkg;
   // instruction classes presented to the unit
   typedef enum logic [2:0] {
      CLS_SINGLE = 3'h0,
      CLS_DP_CMP = 3'h1,
      CLS_TWO_DP = 3'h2,
      CLS_BRANCH = 3'h3,
      CLS_NONE = 3'h4
   } shz_class_t;
   // occupancy cycles of each class, counting the first execute phase
   localparam int unsigned SINGLE_BUSY = 1;
   localparam int unsigned DP_CMP_BUSY = 2;
   localparam int unsigned TWO_DP_BUSY = 2;
   // block masks: bit0 read_decode_block, bit1 write_port_block
   localparam logic [1:0] BLK_READ = 2'h1;
   localparam logic [1:0] BLK_WRITE = 2'h2;
   localparam logic [1:0] BLK_NONE = 2'h0;
endpackage : shz_pkg

// *** shz_issue_if.sv ***
// carrier for per-cycle pending-use flags between the tracker and the top
interface shz_issue_if;
   logic read_pend;
   logic write_pend;
   logic xpath_pend;
   modport tracker (output read_pend, output write_pend, output xpath_pend);
   modport user (input read_pend, input write_pend, input xpath_pend);
endinterface : shz_issue_if

// *** shz_tracker.sv ***
// tracks the second-cycle read, write and cross path use of the unit
module shz_tracker (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   // issued instruction
   input wire logic issue,
   input wire shz_pkg::shz_class_t issue_class,
   input wire logic issue_xpath,
   // pending uses in the following cycle
   shz_issue_if.tracker pend
);
   typedef struct packed {
      logic rd;
      logic wr;
      logic xp;
   } shz_trk_t;
   shz_trk_t s_q, s_d;

   always_comb begin
      s_d = '{rd: 1'b0, wr: 1'b0, xp: 1'b0};
      if (issue) begin
         case (issue_class)
            // compare reads again and writes in its second cycle
            shz_pkg::CLS_DP_CMP: begin
               s_d.rd = 1'b1;
               s_d.wr = 1'b1;
               s_d.xp = issue_xpath;
            end
            // two-cycle op writes remaining half in cycle 2
            shz_pkg::CLS_TWO_DP: s_d.wr = 1'b1;
            // single-cycle and branch leave nothing behind
            default: s_d = '{rd: 1'b0, wr: 1'b0, xp: 1'b0};
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '{rd: 1'b0, wr: 1'b0, xp: 1'b0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign pend.read_pend = s_q.rd;
   assign pend.write_pend = s_q.wr;
   assign pend.xpath_pend = s_q.xp;
endmodule : shz_tracker

// *** shz_hazard.sv ***
// issue hazard logic for one side's shift/logic functional unit
module shz_hazard (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   // candidate for this unit
   input wire logic cand_valid,
   input wire shz_pkg::shz_class_t cand_class,
   input wire logic cand_reg_branch,
   input wire logic cand_xpath,
   // instruction actually entering the first execute phase
   input wire logic first_execute_phase,
   // cross path user on another unit of this side
   input wire logic sib_xpath_valid,
   // permissions
   output logic unit_issue_ok,
   output logic sib_xpath_ok,
   // block reasons for the candidate
   output logic read_decode_block,
   output logic write_port_block
);
   shz_issue_if pend_if ();

   shz_tracker u_trk (
      .mclk(mclk),
      .reset(reset),
      .clk_en(clk_en),
      .issue(first_execute_phase),
      .issue_class(cand_class),
      .issue_xpath(cand_xpath),
      .pend(pend_if.tracker)
   );

   // which blocks apply to a class given pending uses
   function automatic logic [1:0] blk_for(input shz_pkg::shz_class_t c,
                                          input logic reg_br,
                                          input logic rd, input logic wr);
      logic [1:0] m;
      m = shz_pkg::BLK_NONE;
      case (c)
         shz_pkg::CLS_SINGLE, shz_pkg::CLS_TWO_DP: begin
            if (rd) m = m | shz_pkg::BLK_READ;
            if (wr) m = m | shz_pkg::BLK_WRITE;
         end
         shz_pkg::CLS_DP_CMP: if (rd) m = shz_pkg::BLK_READ;
         // other branch forms read no register
         shz_pkg::CLS_BRANCH: if (rd && reg_br) m = shz_pkg::BLK_READ;
         default: m = shz_pkg::BLK_NONE;
      endcase
      return m;
   endfunction : blk_for

   logic [1:0] blk;
   always_comb begin
      blk = blk_for(cand_class, cand_reg_branch, pend_if.read_pend,
                    pend_if.write_pend);
   end

   // permission is combinational so a held op retries next cycle
   assign read_decode_block = cand_valid & blk[0];
   assign write_port_block = cand_valid & blk[1];
   assign unit_issue_ok = cand_valid & (blk == shz_pkg::BLK_NONE);
   // single-cycle leaves no cross path use, compare keeps it in cycle 2
   assign sib_xpath_ok = sib_xpath_valid & ~pend_if.xpath_pend;

   // a held candidate is the dispatcher's job; nothing is queued here

   AST_CMP_BLOCKS_SINGLE: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_DP_CMP)
      ##1 (cand_valid && cand_class == shz_pkg::CLS_SINGLE)
      |-> !unit_issue_ok && read_decode_block && write_port_block)
      else $error("single-cycle op not blocked after compare");
   AST_CMP_READ_ONLY: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_DP_CMP)
      ##1 (cand_valid && cand_class == shz_pkg::CLS_DP_CMP)
      |-> read_decode_block && !write_port_block)
      else $error("compare after compare blocking wrong");
   AST_TWO_DP_WRITE: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_TWO_DP)
      ##1 (cand_valid && cand_class == shz_pkg::CLS_TWO_DP)
      |-> write_port_block && !read_decode_block)
      else $error("two-cycle op not write blocked");
   AST_TWO_DP_BRANCH: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_TWO_DP)
      ##1 (cand_valid && cand_class == shz_pkg::CLS_BRANCH)
      |-> unit_issue_ok)
      else $error("branch wrongly blocked after two-cycle op");
   AST_SINGLE_FREE: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_SINGLE)
      ##1 cand_valid |-> unit_issue_ok)
      else $error("op blocked after single-cycle op");
   AST_SINGLE_XPATH: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_SINGLE)
      ##1 sib_xpath_valid |-> sib_xpath_ok)
      else $error("cross path refused after single-cycle op");
   AST_CMP_XPATH: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class == shz_pkg::CLS_DP_CMP
       && cand_xpath) ##1 1'b1 |-> !sib_xpath_ok)
      else $error("cross path granted during compare");
   AST_NONREG_BRANCH: assert property (@(posedge mclk) disable iff (reset)
      (cand_valid && cand_class == shz_pkg::CLS_BRANCH && !cand_reg_branch)
      |-> unit_issue_ok)
      else $error("non-register branch blocked");
   AST_CLEARS_CYCLE3: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && first_execute_phase && cand_class != shz_pkg::CLS_NONE)
      ##1 (clk_en && !first_execute_phase) ##1 cand_valid
      |-> unit_issue_ok)
      else $error("block lasted past cycle 2");
endmodule : shz_hazard

// *** shz_dispatch.sv ***
// dispatch stage model that feeds candidates to the hazard block
module shz_dispatch (
   // request from the bench
   input wire logic want,
   input wire logic issue_en,
   input wire shz_pkg::shz_class_t cls,
   input wire logic reg_br,
   input wire logic xp,
   // permission from the hazard block
   input wire logic unit_issue_ok,
   // candidate towards the hazard block
   output logic cand_valid,
   output shz_pkg::shz_class_t cand_class,
   output logic cand_reg_branch,
   output logic cand_xpath,
   output logic first_execute_phase
);
   // a refused candidate stays presented unchanged until it may enter
   assign cand_valid = want;
   assign cand_class = want ? cls : shz_pkg::CLS_NONE;
   assign cand_reg_branch = want & reg_br;
   assign cand_xpath = want & xp;
   // issue only under permission, so no op is ever lost or reordered
   assign first_execute_phase = want & issue_en & unit_issue_ok;
endmodule : shz_dispatch

// *** shifter_unit_issue_hazards_bench.sv ***
// self-checking bench for the shift/logic unit issue hazard block
module shifter_unit_issue_hazards_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, reset, clk_en, want, en, rb, xp, sib_v;
   logic cv, crb, cx, fep, ok, sok, rdb, wrb;
   shz_pkg::shz_class_t cls, ccls;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   // short aliases keep the scenario lines inside the line width
   localparam shz_pkg::shz_class_t K_S = shz_pkg::CLS_SINGLE;
   localparam shz_pkg::shz_class_t K_C = shz_pkg::CLS_DP_CMP;
   localparam shz_pkg::shz_class_t K_T = shz_pkg::CLS_TWO_DP;
   localparam shz_pkg::shz_class_t K_B = shz_pkg::CLS_BRANCH;
   shz_dispatch disp_u (.want(want), .issue_en(en), .cls(cls),
      .reg_br(rb), .xp(xp), .unit_issue_ok(ok), .cand_valid(cv),
      .cand_class(ccls), .cand_reg_branch(crb), .cand_xpath(cx),
      .first_execute_phase(fep));
   shz_hazard dut_u (.mclk(mclk), .reset(reset), .clk_en(clk_en),
      .cand_valid(cv), .cand_class(ccls), .cand_reg_branch(crb),
      .cand_xpath(cx), .first_execute_phase(fep),
      .sib_xpath_valid(sib_v), .unit_issue_ok(ok), .sib_xpath_ok(sok),
      .read_decode_block(rdb), .write_port_block(wrb));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // the whole run needs some 56 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count = fail_count + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(string what, logic [4:0] exp);
      checks = checks + 1;
      if ({fep, ok, rdb, wrb, sok} !== exp) begin
         fail_count = fail_count + 1;
         $display("[ERR] %s expected %h seen %h", what, exp,
            {fep, ok, rdb, wrb, sok});
      end
   endtask : chk
   // candidate is presented at the falling edge and enters at the next rise
   task automatic op(shz_pkg::shz_class_t c, logic x);
      @(negedge mclk);
      {want, en, cls, rb, xp} = {2'h3, c, 1'b0, x};
   endtask : op
   task automatic probe(shz_pkg::shz_class_t c, logic r);
      @(negedge mclk);
      {want, en, cls, rb, xp} = {2'h2, c, r, 1'b0};
      #1;
   endtask : probe
   task automatic pair(string what, shz_pkg::shz_class_t f, logic x,
         shz_pkg::shz_class_t p, logic r, logic [4:0] exp);
      op(f, x);
      probe(p, r);
      chk(what, exp);
      probe(p, r);
      chk(what, 5'h09);
   endtask : pair
   task automatic t_single();
      for (int i = 0; i < 4; i++) begin
         pair("single", shz_pkg::CLS_SINGLE, 1'b1,
            shz_pkg::shz_class_t'(i), 1'b1, 5'h09);
      end
   endtask : t_single
   task automatic t_compare();
      pair("cmp_s", K_C, 1'b1, K_S, 1'b0, 5'h06);
      pair("cmp_t", K_C, 1'b1, K_T, 1'b0, 5'h06);
      pair("cmp_c", K_C, 1'b1, K_C, 1'b0, 5'h04);
      pair("cmp_rb", K_C, 1'b1, K_B, 1'b1, 5'h04);
      pair("cmp_b", K_C, 1'b1, K_B, 1'b0, 5'h08);
      pair("cmp_loc", K_C, 1'b0, K_S, 1'b0, 5'h07);
   endtask : t_compare
   task automatic t_two();
      pair("two_s", K_T, 1'b0, K_S, 1'b0, 5'h03);
      pair("two_t", K_T, 1'b1, K_T, 1'b0, 5'h03);
      pair("two_b", K_T, 1'b0, K_B, 1'b1, 5'h09);
      pair("two_c", K_T, 1'b0, K_C, 1'b0, 5'h09);
   endtask : t_two
   // a refused op is held, then enters one cycle later; clk_en freezes
   task automatic t_hold();
      op(shz_pkg::CLS_DP_CMP, 1'b1);
      op(shz_pkg::CLS_SINGLE, 1'b0);
      #1;
      chk("held", 5'h06);
      op(shz_pkg::CLS_SINGLE, 1'b0);
      #1;
      chk("retry", 5'h19);
      op(shz_pkg::CLS_DP_CMP, 1'b1);
      probe(shz_pkg::CLS_SINGLE, 1'b0);
      clk_en = 1'b0;
      chk("frz1", 5'h06);
      probe(shz_pkg::CLS_SINGLE, 1'b0);
      chk("frz2", 5'h06);
      clk_en = 1'b1;
      probe(shz_pkg::CLS_SINGLE, 1'b0);
      chk("thaw", 5'h09);
      op(shz_pkg::CLS_DP_CMP, 1'b1);
      probe(shz_pkg::CLS_SINGLE, 1'b0);
      // freeze while resetting so only the reset can clear the block
      clk_en = 1'b0;
      reset = 1'b1;
      probe(shz_pkg::CLS_SINGLE, 1'b0);
      reset = 1'b0;
      chk("rst", 5'h09);
      clk_en = 1'b1;
   endtask : t_hold
   initial begin
      {reset, clk_en, want, en, rb, xp, sib_v} = 7'h60;
      cls = shz_pkg::CLS_NONE;
      repeat (4) @(negedge mclk);
      reset = 1'b0;
      sib_v = 1'b1;
      t_single();
      t_compare();
      t_two();
      t_hold();
      wrap_up();
   end
endmodule : shifter_unit_issue_hazards_bench
